/* design/prsc_consts.svh */
// constants of the presence status and reader id command handler
`ifndef PRSC_CONSTS_SVH
`define PRSC_CONSTS_SVH

// clock and time base
`define PRSC_CLK_NS 25
`define PRSC_MS_NS 1000000
`define PRSC_CYC_PER_MS (`PRSC_MS_NS / `PRSC_CLK_NS)

// register byte addresses
`define PRSC_ADDR_CTRL 8'h00
`define PRSC_ADDR_READER_ID 8'h04
`define PRSC_ADDR_IRQ_STATUS 8'h08
`define PRSC_ADDR_IRQ_ENABLE 8'h0c
`define PRSC_ADDR_IRQ_CLEAR 8'h10

// control register fields
`define PRSC_CTRL_REPORT 0
`define PRSC_CTRL_POL_LSB 1
`define PRSC_CTRL_POL_MSB 2
`define PRSC_CTRL_TMO_LSB 3
`define PRSC_CTRL_TMO_MSB 6
`define PRSC_CTRL_INVERT 7

// interrupt bits
`define PRSC_IRQ_DONE 0
`define PRSC_IRQ_ERROR 1
`define PRSC_IRQ_EXPIRE 2
`define PRSC_IRQ_W 3

// reset values
`define PRSC_RST_REPORT 1'b0
`define PRSC_RST_POLICY 2'h0
`define PRSC_RST_TMO 4'hf
`define PRSC_RST_INVERT 1'b0
`define PRSC_RST_READER_ID 8'h00

// command codes, right aligned hex digits
`define PRSC_CMD_STATUS 24'h000529
`define PRSC_CMD_READ_ID 24'h000521
`define PRSC_CMD_RPT_OFF 24'h006900
`define PRSC_CMD_RPT_OFF_ALT 24'h000900
`define PRSC_CMD_RPT_ON 24'h006901
`define PRSC_CMD_POL_TMO 24'h006920
`define PRSC_CMD_POL_TAG 24'h006921
`define PRSC_CMD_POL_NOPRES 24'h006922
`define PRSC_CMD_TMO_PFX 12'h693
`define PRSC_LEN_SHORT 3'd3
`define PRSC_LEN_LONG 3'd4
`define PRSC_MAX_DIGITS 3'd6

// ascii
`define PRSC_CH_CR 8'h0d
`define PRSC_CH_0 8'h30
`define PRSC_CH_9 8'h39
`define PRSC_CH_UA 8'h41
`define PRSC_CH_UF 8'h46
`define PRSC_CH_LA 8'h61
`define PRSC_CH_LF 8'h66
`define PRSC_HEX_ALPHA 8'h0a

// field values
`define PRSC_POL_TMO 2'h0
`define PRSC_POL_TAG 2'h1
`define PRSC_POL_NOPRES 2'h2
`define PRSC_TMO_ZERO 4'h0
`define PRSC_TMO_INF 4'hf
`define PRSC_MIN_PRES 4'h0

// reply lengths in characters, terminator included
`define PRSC_LEN_STATUS 5'd20
`define PRSC_LEN_DONE 5'd5
`define PRSC_LEN_ID 5'd8
`define PRSC_LEN_ERR 5'd6

// rf timeout codes 1 to e in milliseconds
`define PRSC_TMO_MS_1 10'd4
`define PRSC_TMO_MS_2 10'd8
`define PRSC_TMO_MS_3 10'd12
`define PRSC_TMO_MS_4 10'd20
`define PRSC_TMO_MS_5 10'd32
`define PRSC_TMO_MS_6 10'd32
`define PRSC_TMO_MS_7 10'd48
`define PRSC_TMO_MS_8 10'd60
`define PRSC_TMO_MS_9 10'd92
`define PRSC_TMO_MS_A 10'd152
`define PRSC_TMO_MS_B 10'd300
`define PRSC_TMO_MS_C 10'd452
`define PRSC_TMO_MS_D 10'd600
`define PRSC_TMO_MS_E 10'd752

`endif

/* design/prsc_pkg.sv */
// types and the timeout table of the presence status command handler
`include "prsc_consts.svh"

package prsc_pkg;

    typedef enum logic [0:0] {ST_IDLE, ST_SEND} prsc_state_t;

    typedef enum logic [1:0] {RP_DONE, RP_STATUS, RP_ID, RP_ERR} prsc_reply_t;

    typedef struct packed {
        logic report_en;
        logic [1:0] policy;
        logic [3:0] tmo;
        logic invert;
        logic [7:0] reader_id;
        logic [`PRSC_IRQ_W-1:0] irq_stat;
        logic [`PRSC_IRQ_W-1:0] irq_en;
        logic [31:0] rdata;
        logic [23:0] cmd_buf;
        logic [2:0] ndig;
        logic bad;
        prsc_state_t state;
        prsc_reply_t reply;
        logic [4:0] idx;
        logic [7:0] rsp_char;
        logic rsp_valid;
        logic rsp_last;
        logic tmr_run;
        logic [15:0] tmr_pre;
        logic [9:0] tmr_ms;
        logic expired;
    } prsc_regs_t;

    function automatic logic [9:0] prsc_tmo_ms(input logic [3:0] code);
        logic [9:0] ms;
        ms = '0;
        unique case (code)
            4'h1: ms = `PRSC_TMO_MS_1;
            4'h2: ms = `PRSC_TMO_MS_2;
            4'h3: ms = `PRSC_TMO_MS_3;
            4'h4: ms = `PRSC_TMO_MS_4;
            4'h5: ms = `PRSC_TMO_MS_5;
            4'h6: ms = `PRSC_TMO_MS_6;
            4'h7: ms = `PRSC_TMO_MS_7;
            4'h8: ms = `PRSC_TMO_MS_8;
            4'h9: ms = `PRSC_TMO_MS_9;
            4'ha: ms = `PRSC_TMO_MS_A;
            4'hb: ms = `PRSC_TMO_MS_B;
            4'hc: ms = `PRSC_TMO_MS_C;
            4'hd: ms = `PRSC_TMO_MS_D;
            4'he: ms = `PRSC_TMO_MS_E;
            default: ms = '0;
        endcase
        return ms;
    endfunction

endpackage

/* design/prsc_hex_ascii.sv */
// one nibble to its upper case ascii hex digit
`timescale 1ns/1ps
`include "prsc_consts.svh"

module prsc_hex_ascii (
    input wire logic [3:0] nibble_i,
    output logic [7:0] char_o
);
    always_comb begin
        if (nibble_i < 4'ha) begin
            char_o = `PRSC_CH_0 + {4'h0, nibble_i};
        end else begin
            char_o = `PRSC_CH_UA + {4'h0, nibble_i} - `PRSC_HEX_ALPHA;
        end
    end
endmodule

/* design/prsc_cmd.sv */
// presence status, presence report and reader id command handler
// Behaviour
// - command 529 answers with the presence status string and its five fields
// - report option field shows 1 when presence reports are on, else 0
// - minimum presence period field always shows 0, meaning zero milliseconds
// - rf-off policy field shows 0 for timeout only, 1 for timeout or tag
// - rf-off policy field shows 2 for timeout or no presence
// - timeout code 0 is a zero timeout that always counts as expired
// - timeout codes 1 to e map to 4 through 752 milliseconds in order
// - timeout code f never expires and is the reset default
// - inversion field shows 0 when disabled, the default, 1 when enabled
// - command 6901 turns presence reports on and answers Done
// - command 6900 or 0900 turns presence reports off and answers Done
// - command 521 answers with the reader id as two hex digits
// - commands 6920, 6921, 6922 select rf-off policy 0, 1, 2
// - command 693 plus one hex digit sets the timeout code, answers Done
`timescale 1ns/1ps
`include "prsc_consts.svh"

module prsc_cmd #(
    parameter int unsigned CYCLES_PER_MS = `PRSC_CYC_PER_MS
) (
    input wire logic MCLK_I,
    input wire logic RSTN_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    input wire logic [7:0] CMD_CHAR_I,
    input wire logic CMD_VALID_I,
    output logic CMD_READY_O,
    output logic [7:0] RSP_CHAR_O,
    output logic RSP_VALID_O,
    output logic RSP_LAST_O,
    input wire logic RSP_READY_I,
    input wire logic RF_TIMER_START_I,
    output logic RF_TIMEOUT_EXPIRED_O,
    output logic REPORT_ENABLE_O,
    output logic [1:0] RF_OFF_POLICY_O,
    output logic [3:0] RF_TIMEOUT_CODE_O,
    output logic INPUT_INVERT_O,
    output logic [7:0] READER_ID_O,
    output logic IRQ_O
);
    import prsc_pkg::*;

    // prescaler end value: one tick of the millisecond counter
    localparam logic [15:0] PRE_LAST = 16'(CYCLES_PER_MS - 1);

    // reset leaves reports off, policy 0, infinite timeout and no inversion
    localparam prsc_regs_t REGS_RST = '{
        report_en: `PRSC_RST_REPORT,
        policy: `PRSC_RST_POLICY,
        tmo: `PRSC_RST_TMO,
        invert: `PRSC_RST_INVERT,
        reader_id: `PRSC_RST_READER_ID,
        irq_stat: '0,
        irq_en: '0,
        rdata: '0,
        cmd_buf: '0,
        ndig: '0,
        bad: 1'b0,
        state: ST_IDLE,
        reply: RP_DONE,
        idx: '0,
        rsp_char: '0,
        rsp_valid: 1'b0,
        rsp_last: 1'b0,
        tmr_run: 1'b0,
        tmr_pre: '0,
        tmr_ms: '0,
        expired: 1'b0
    };

    prsc_regs_t r_q;
    prsc_regs_t r_d;

    // hex digits of the reply fields, order fixed by the message layout below
    // a reply shows the settings as they stand when each character is built
    logic [3:0] nib [7];
    logic [55:0] hx;

    assign nib[0] = {3'h0, r_q.report_en};
    assign nib[1] = `PRSC_MIN_PRES;
    assign nib[2] = {2'h0, r_q.policy};
    assign nib[3] = r_q.tmo;
    assign nib[4] = {3'h0, r_q.invert};
    assign nib[5] = r_q.reader_id[7:4];
    assign nib[6] = r_q.reader_id[3:0];

    for (genvar g = 0; g < 7; g++) begin : g_hex
        prsc_hex_ascii u_hex (
            .nibble_i(nib[g]),
            .char_o(hx[55-8*g -: 8])
        );
    end

    // messages are left aligned in a 20 byte vector, byte 0 leftmost
    function automatic logic [7:0] reply_char(
        input prsc_reply_t kind,
        input logic [4:0] idx,
        input logic [55:0] h
    );
        logic [159:0] msg;
        msg = '0;
        unique case (kind)
            // unused tail bytes stay zero; only reply_len bytes are ever sent
            RP_STATUS: msg = {"PR", "ST P", h[55:48], " D", h[47:40], " A", h[39:32],
                              " T", h[31:24], " I", h[23:16], `PRSC_CH_CR};
            RP_DONE: msg = {"Done", `PRSC_CH_CR, 120'h0};
            RP_ID: msg = {"RD", "ID ", h[15:8], h[7:0], `PRSC_CH_CR, 96'h0};
            RP_ERR: msg = {"Error", `PRSC_CH_CR, 112'h0};
        endcase
        return msg[(8'd159 - {idx, 3'h0}) -: 8];
    endfunction

    function automatic logic [4:0] reply_len(input prsc_reply_t kind);
        logic [4:0] len;
        len = `PRSC_LEN_DONE;
        unique case (kind)
            RP_STATUS: len = `PRSC_LEN_STATUS;
            RP_DONE: len = `PRSC_LEN_DONE;
            RP_ID: len = `PRSC_LEN_ID;
            RP_ERR: len = `PRSC_LEN_ERR;
        endcase
        return len;
    endfunction

    // returns {is_hex, value}; both cases of letters are taken
    function automatic logic [4:0] hex_val(input logic [7:0] ch);
        logic [4:0] v;
        v = '0;
        if (ch >= `PRSC_CH_0 && ch <= `PRSC_CH_9) begin
            v = {1'b1, 4'(ch - `PRSC_CH_0)};
        end else if (ch >= `PRSC_CH_UA && ch <= `PRSC_CH_UF) begin
            v = {1'b1, 4'(ch - `PRSC_CH_UA + `PRSC_HEX_ALPHA)};
        end else if (ch >= `PRSC_CH_LA && ch <= `PRSC_CH_LF) begin
            v = {1'b1, 4'(ch - `PRSC_CH_LA + `PRSC_HEX_ALPHA)};
        end
        return v;
    endfunction

    always_comb begin
        logic [`PRSC_IRQ_W-1:0] ev;
        logic [4:0] hv;
        prsc_reply_t kind;
        ev = '0;
        hv = hex_val(CMD_CHAR_I);
        kind = RP_ERR;
        r_d = r_q;
        r_d.rdata = '0;

        // register reads: data valid only in the cycle after the strobe
        // the clear register reads as zero, like any unmapped address
        if (RD_I) begin
            unique case (ADDR_I)
                `PRSC_ADDR_CTRL: r_d.rdata = {24'h0, r_q.invert, r_q.tmo, r_q.policy,
                                              r_q.report_en};
                `PRSC_ADDR_READER_ID: r_d.rdata = {24'h0, r_q.reader_id};
                `PRSC_ADDR_IRQ_STATUS: r_d.rdata = {29'h0, r_q.irq_stat};
                `PRSC_ADDR_IRQ_ENABLE: r_d.rdata = {29'h0, r_q.irq_en};
                default: r_d.rdata = '0;
            endcase
        end

        // register writes; a command decoded in the same cycle overrides them
        // status writes are ignored; only hardware events set status bits
        if (WR_I) begin
            unique case (ADDR_I)
                `PRSC_ADDR_CTRL: begin
                    r_d.report_en = WDATA_I[`PRSC_CTRL_REPORT];
                    r_d.policy = WDATA_I[`PRSC_CTRL_POL_MSB:`PRSC_CTRL_POL_LSB];
                    r_d.tmo = WDATA_I[`PRSC_CTRL_TMO_MSB:`PRSC_CTRL_TMO_LSB];
                    r_d.invert = WDATA_I[`PRSC_CTRL_INVERT];
                end
                `PRSC_ADDR_READER_ID: r_d.reader_id = WDATA_I[7:0];
                `PRSC_ADDR_IRQ_ENABLE: r_d.irq_en = WDATA_I[`PRSC_IRQ_W-1:0];
                `PRSC_ADDR_IRQ_CLEAR: r_d.irq_stat = r_q.irq_stat & ~WDATA_I[`PRSC_IRQ_W-1:0];
                default: ;
            endcase
        end

        // command intake, only while no reply is being sent
        // digits shift in from the right, so codes compare right aligned
        if (CMD_VALID_I && r_q.state == ST_IDLE) begin
            if (CMD_CHAR_I == `PRSC_CH_CR) begin
                if (!r_q.bad && r_q.ndig == `PRSC_LEN_SHORT) begin
                    unique case (r_q.cmd_buf)
                        `PRSC_CMD_STATUS: kind = RP_STATUS;
                        `PRSC_CMD_READ_ID: kind = RP_ID;
                        default: kind = RP_ERR;
                    endcase
                end else if (!r_q.bad && r_q.ndig == `PRSC_LEN_LONG) begin
                    kind = RP_DONE;
                    // both spellings of the disable code are taken
                    unique case (r_q.cmd_buf)
                        `PRSC_CMD_RPT_ON: r_d.report_en = 1'b1;
                        `PRSC_CMD_RPT_OFF, `PRSC_CMD_RPT_OFF_ALT: r_d.report_en = 1'b0;
                        `PRSC_CMD_POL_TMO: r_d.policy = `PRSC_POL_TMO;
                        `PRSC_CMD_POL_TAG: r_d.policy = `PRSC_POL_TAG;
                        `PRSC_CMD_POL_NOPRES: r_d.policy = `PRSC_POL_NOPRES;
                        default: begin
                            // any other four digit code must be 693 plus a digit
                            if (r_q.cmd_buf[15:4] == `PRSC_CMD_TMO_PFX) begin
                                r_d.tmo = r_q.cmd_buf[3:0];
                            end else begin
                                kind = RP_ERR;
                            end
                        end
                    endcase
                end
                ev[`PRSC_IRQ_DONE] = (kind != RP_ERR);
                ev[`PRSC_IRQ_ERROR] = (kind == RP_ERR);
                r_d.cmd_buf = '0;
                r_d.ndig = '0;
                r_d.bad = 1'b0;
                r_d.state = ST_SEND;
                r_d.reply = kind;
                r_d.idx = '0;
                r_d.rsp_char = reply_char(kind, 5'h0, hx);
                r_d.rsp_valid = 1'b1;
                r_d.rsp_last = 1'b0;
            end else if (hv[4] && r_q.ndig != `PRSC_MAX_DIGITS) begin
                r_d.cmd_buf = {r_q.cmd_buf[19:0], hv[3:0]};
                r_d.ndig = r_q.ndig + 3'h1;
            end else begin
                // a stray character or an overlong code spoils the whole line
                r_d.bad = 1'b1;
            end
        end

        // reply character stream
        // last is set one character early so it stands beside the terminator
        if (r_q.state == ST_SEND && RSP_READY_I) begin
            if (r_q.rsp_last) begin
                r_d.state = ST_IDLE;
                r_d.rsp_valid = 1'b0;
                r_d.rsp_last = 1'b0;
            end else begin
                r_d.idx = r_q.idx + 5'h1;
                r_d.rsp_char = reply_char(r_q.reply, r_q.idx + 5'h1, hx);
                r_d.rsp_last = (r_q.idx + 5'h2 == reply_len(r_q.reply));
            end
        end

        // rf timeout timer; the code is sampled at start, later changes wait
        // a restart while running reloads the count from the current code
        // code 0 flags at once and code f never starts the counter
        // the prescaler divides the clock down to whole milliseconds
        if (RF_TIMER_START_I) begin
            r_d.tmr_pre = '0;
            r_d.tmr_ms = prsc_tmo_ms(r_q.tmo);
            r_d.tmr_run = (r_q.tmo != `PRSC_TMO_ZERO) && (r_q.tmo != `PRSC_TMO_INF);
            r_d.expired = (r_q.tmo == `PRSC_TMO_ZERO);
            ev[`PRSC_IRQ_EXPIRE] = (r_q.tmo == `PRSC_TMO_ZERO);
        end else if (r_q.tmr_run) begin
            if (r_q.tmr_pre == PRE_LAST) begin
                r_d.tmr_pre = '0;
                if (r_q.tmr_ms == 10'h1) begin
                    r_d.tmr_run = 1'b0;
                    r_d.expired = 1'b1;
                    ev[`PRSC_IRQ_EXPIRE] = 1'b1;
                end else begin
                    r_d.tmr_ms = r_q.tmr_ms - 10'h1;
                end
            end else begin
                r_d.tmr_pre = r_q.tmr_pre + 16'h1;
            end
        end

        // events are applied after the clear, so a set in the same cycle wins
        r_d.irq_stat = r_d.irq_stat | ev;
    end

    // one register for all state keeps reset and update in one place
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            r_q <= REGS_RST;
        end else begin
            r_q <= r_d;
        end
    end

    // outputs come straight from the state register
    assign RDATA_O = r_q.rdata;
    assign CMD_READY_O = (r_q.state == ST_IDLE);
    assign RSP_CHAR_O = r_q.rsp_char;
    assign RSP_VALID_O = r_q.rsp_valid;
    assign RSP_LAST_O = r_q.rsp_last;
    // code f never expires, code 0 always counts as expired
    assign RF_TIMEOUT_EXPIRED_O = (r_q.tmo != `PRSC_TMO_INF)
                                  && (r_q.expired || r_q.tmo == `PRSC_TMO_ZERO);
    assign REPORT_ENABLE_O = r_q.report_en;
    assign RF_OFF_POLICY_O = r_q.policy;
    assign RF_TIMEOUT_CODE_O = r_q.tmo;
    assign INPUT_INVERT_O = r_q.invert;
    assign READER_ID_O = r_q.reader_id;
    // level interrupt: follows status and enable with no extra register
    assign IRQ_O = |(r_q.irq_stat & r_q.irq_en);

endmodule

/* verif/prsc_cmd_chk.sv */
// port level checks of the presence status command handler
`timescale 1ns/1ps

module prsc_cmd_chk #(
    parameter int unsigned CYCLES_PER_MS = 4
) (
    input wire logic MCLK_I,
    input wire logic RSTN_I,
    input wire logic RD_I,
    input wire logic [31:0] RDATA_O,
    input wire logic [7:0] CMD_CHAR_I,
    input wire logic CMD_VALID_I,
    input wire logic CMD_READY_O,
    input wire logic [7:0] RSP_CHAR_O,
    input wire logic RSP_VALID_O,
    input wire logic RSP_LAST_O,
    input wire logic RSP_READY_I,
    input wire logic RF_TIMER_START_I,
    input wire logic RF_TIMEOUT_EXPIRED_O,
    input wire logic [3:0] RF_TIMEOUT_CODE_O
);
    logic [15:0] tcnt_q;

    // cycles since the last timer start; saturates so a long idle never wraps
    always_ff @(posedge MCLK_I) begin
        if (RF_TIMER_START_I) begin
            tcnt_q <= 16'h0000;
        end else if (tcnt_q != 16'hffff) begin
            tcnt_q <= tcnt_q + 16'h0001;
        end
    end

    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RSTN_I);

    a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
        else $error("read data not zero outside read slot");
    a_busy_reply: assert property (RSP_VALID_O |-> !CMD_READY_O)
        else $error("command intake open during reply");
    a_last_cr: assert property (RSP_LAST_O |-> RSP_VALID_O && RSP_CHAR_O == 8'h0d)
        else $error("last reply char is not the terminator");
    a_char_hold: assert property (RSP_VALID_O && !RSP_READY_I |=>
        RSP_VALID_O && $stable(RSP_CHAR_O) && $stable(RSP_LAST_O))
        else $error("reply char changed while stalled");
    a_reply_start: assert property (CMD_VALID_I && CMD_READY_O && CMD_CHAR_I == 8'h0d
        |=> RSP_VALID_O && !CMD_READY_O)
        else $error("no reply after command end");
    a_ready_back: assert property (RSP_VALID_O && RSP_READY_I && RSP_LAST_O
        |=> !RSP_VALID_O && CMD_READY_O)
        else $error("intake not reopened after reply");
    a_zero_tmo: assert property (RF_TIMER_START_I && RF_TIMEOUT_CODE_O == 4'h0
        |=> RF_TIMEOUT_EXPIRED_O)
        else $error("zero timeout not expired at once");
    a_inf_tmo: assert property (RF_TIMEOUT_CODE_O == 4'hf |-> !RF_TIMEOUT_EXPIRED_O)
        else $error("infinite timeout expired");
    a_tmo_len: assert property ($rose(RF_TIMEOUT_EXPIRED_O) && RF_TIMEOUT_CODE_O == 4'h1
        && $stable(RF_TIMEOUT_CODE_O)
        |-> tcnt_q + 1 >= 4 * CYCLES_PER_MS && tcnt_q <= 4 * CYCLES_PER_MS + 1)
        else $error("shortest timeout has wrong length");
    a_exp_stands: assert property (RF_TIMEOUT_EXPIRED_O && !RF_TIMER_START_I
        |=> RF_TIMEOUT_EXPIRED_O || $changed(RF_TIMEOUT_CODE_O))
        else $error("expiry dropped without restart");
endmodule

/* verif/prsc_host.sv */
// host model: sends numeric commands and collects the reply text
`timescale 1ns/1ps

module prsc_host (
    input wire logic clk_i,
    input wire logic slow_i,
    output logic [7:0] char_o,
    output logic valid_o,
    input wire logic [7:0] rsp_char_i,
    input wire logic rsp_valid_i,
    input wire logic rsp_last_i,
    output logic rsp_ready_o
);
    logic [159:0] rx_q = '0;
    logic got_q = 1'b0;
    logic tog_q = 1'b0;

    initial begin
        char_o = 8'h00;
        valid_o = 1'b0;
        rsp_ready_o = 1'b0;
    end

    // a slow host is ready only every other cycle so the stall path is exercised
    always @(posedge clk_i) begin
        tog_q <= ~tog_q;
        rsp_ready_o <= slow_i ? tog_q : 1'b1;
        if (rsp_valid_i && rsp_ready_o) begin
            rx_q <= {rx_q[151:0], rsp_char_i};
            got_q <= rsp_last_i;
        end
    end

    task automatic send(input string s);
        rx_q = '0;
        got_q = 1'b0;
        for (int i = 0; i <= s.len(); i++) begin
            @(posedge clk_i);
            valid_o <= 1'b1;
            char_o <= (i == s.len()) ? 8'h0d : s[i];
        end
        @(posedge clk_i);
        valid_o <= 1'b0;
        // a released line shows the inverse, never a held copy of the last char
        char_o <= ~char_o;
    endtask
endmodule

/* verif/presence_status_and_reader_id_cmds_tb_top.sv */
// testbench of the presence status and reader id command handler
`timescale 1ns/1ps
`include "prsc_consts.svh"

module presence_status_and_reader_id_cmds_tb_top;
    localparam int CPM = 4;
    localparam logic [159:0] DONE_S = {"Done", 8'h0d};
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic tstart = 1'b0;
    logic slow = 1'b0;
    logic [31:0] rdata;
    logic [7:0] cmd_char, rsp_char, id_o;
    logic cmd_valid, cmd_ready, rsp_valid, rsp_last, rsp_ready, expired, rpt_o, inv_o, irq;
    logic [1:0] pol_o;
    logic [3:0] tmo_o;
    int miscompares = 0;
    int num_checks = 0;
    integer seed = 32'h59572e1c;
    logic rpt = 1'b0;
    logic [1:0] pol = 2'h0;
    logic [3:0] tmo = 4'hf;
    logic inv = 1'b0;
    logic [7:0] id = 8'h00;
    int ms_tab [16] = '{0, 4, 8, 12, 20, 32, 32, 48, 60, 92, 152, 300, 452, 600, 752, 0};

    always #12.5 mclk = ~mclk;

    prsc_cmd #(.CYCLES_PER_MS(CPM)) DUT (
        .MCLK_I(mclk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .CMD_CHAR_I(cmd_char), .CMD_VALID_I(cmd_valid),
        .CMD_READY_O(cmd_ready), .RSP_CHAR_O(rsp_char), .RSP_VALID_O(rsp_valid),
        .RSP_LAST_O(rsp_last), .RSP_READY_I(rsp_ready), .RF_TIMER_START_I(tstart),
        .RF_TIMEOUT_EXPIRED_O(expired), .REPORT_ENABLE_O(rpt_o), .RF_OFF_POLICY_O(pol_o),
        .RF_TIMEOUT_CODE_O(tmo_o), .INPUT_INVERT_O(inv_o), .READER_ID_O(id_o), .IRQ_O(irq));

    prsc_host u_host (.clk_i(mclk), .slow_i(slow), .char_o(cmd_char), .valid_o(cmd_valid),
        .rsp_char_i(rsp_char), .rsp_valid_i(rsp_valid), .rsp_last_i(rsp_last),
        .rsp_ready_o(rsp_ready));

    function automatic logic [7:0] hx(input logic [3:0] n);
        return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    endfunction

    function automatic logic [159:0] stat_exp();
        return {"PR", "ST", " P", hx({3'h0, rpt}), " D", "0 A", hx({2'h0, pol}), " T", hx(tmo),
            " I", hx({3'h0, inv}), 8'h0d};
    endfunction

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [159:0] seen, input logic [159:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk("rdata", rdata, e);
    endtask

    task automatic cmd(input string s, input logic [159:0] e);
        int n;
        n = 0;
        u_host.send(s);
        while (u_host.got_q !== 1'b1 && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n == 100) begin
            miscompares++;
            print_verdict();
        end
        chk(s, u_host.rx_q, e);
        @(posedge mclk);
        #1;
    endtask

    initial begin
        logic [31:0] r;
        int n;
        int lim;
        logic ok;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        rd_chk(`PRSC_ADDR_CTRL, 32'h78);
        rd_chk(8'h14, 32'h0);
        cmd("529", stat_exp());
        cmd("521", {"RD", "ID", " 00", 8'h0d});
        rpt = 1'b1;
        cmd("6901", DONE_S);
        chk("report", rpt_o, 1'b1);
        cmd("529", stat_exp());
        rpt = 1'b0;
        cmd("6900", DONE_S);
        chk("report", rpt_o, 1'b0);
        cmd("6901", DONE_S);
        cmd("0900", DONE_S);
        cmd("529", stat_exp());
        slow = 1'b1;
        for (int p = 0; p < 3; p++) begin
            pol = p[1:0];
            cmd($sformatf("692%0d", p), DONE_S);
            chk("policy", pol_o, pol);
            cmd("529", stat_exp());
        end
        slow = 1'b0;
        wr_reg(`PRSC_ADDR_IRQ_ENABLE, 32'h4);
        for (int k = 0; k < 16; k++) begin
            tmo = k[3:0];
            lim = ms_tab[k] * CPM;
            cmd($sformatf("693%h", tmo), DONE_S);
            chk("code", tmo_o, tmo);
            cmd("529", stat_exp());
            wr_reg(`PRSC_ADDR_IRQ_CLEAR, 32'h4);
            @(posedge mclk);
            tstart <= 1'b1;
            @(posedge mclk);
            tstart <= 1'b0;
            #1;
            n = 0;
            while (expired !== 1'b1 && n < 3100) begin
                @(posedge mclk);
                #1;
                n++;
            end
            ok = (tmo == 4'hf) ? n == 3100 : n + 1 >= lim && n <= lim + 1;
            chk("expiry", ok, 1'b1);
            chk("irq", irq, tmo != 4'hf);
        end
        for (int k = 0; k < 6; k++) begin
            r = (k == 0) ? 32'hff87 : $random(seed);
            {inv, tmo, pol, rpt} = r[7:0];
            id = r[15:8];
            wr_reg(`PRSC_ADDR_CTRL, {24'h0, r[7:0]});
            wr_reg(`PRSC_ADDR_READER_ID, {24'h0, id});
            rd_chk(`PRSC_ADDR_CTRL, {24'h0, r[7:0]});
            cmd("529", stat_exp());
            cmd("521", {"RD", "ID", " ", hx(id[7:4]), hx(id[3:0]), 8'h0d});
            chk("id", id_o, id);
            chk("invert", inv_o, inv);
        end
        cmd("5z9", {"Error", 8'h0d});
        cmd("6901234", {"Error", 8'h0d});
        wr_reg(`PRSC_ADDR_IRQ_CLEAR, 32'h7);
        wr_reg(`PRSC_ADDR_IRQ_ENABLE, 32'h0);
        cmd("0529", {"Error", 8'h0d});
        chk("irq", irq, 1'b0);
        rd_chk(`PRSC_ADDR_IRQ_STATUS, 32'h2);
        wr_reg(`PRSC_ADDR_IRQ_ENABLE, 32'h2);
        chk("irq", irq, 1'b1);
        wr_reg(`PRSC_ADDR_IRQ_CLEAR, 32'h2);
        chk("irq", irq, 1'b0);
        print_verdict();
    end
endmodule

bind prsc_cmd prsc_cmd_chk #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_chk (
    .MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .CMD_CHAR_I(CMD_CHAR_I), .CMD_VALID_I(CMD_VALID_I), .CMD_READY_O(CMD_READY_O),
    .RSP_CHAR_O(RSP_CHAR_O), .RSP_VALID_O(RSP_VALID_O), .RSP_LAST_O(RSP_LAST_O),
    .RSP_READY_I(RSP_READY_I), .RF_TIMER_START_I(RF_TIMER_START_I),
    .RF_TIMEOUT_EXPIRED_O(RF_TIMEOUT_EXPIRED_O), .RF_TIMEOUT_CODE_O(RF_TIMEOUT_CODE_O));
